// ### rtl/uafs_regs.svh
// Purpose: register offsets, field positions, reset values, timing counts
// Assumes: Avalon-MM word addressing, 8-bit data in low lanes
// Notes: included by both ends
`ifndef UAFS_REGS_SVH
`define UAFS_REGS_SVH
`define UAFS_OFF_APP_STATUS 3'h0
`define UAFS_OFF_FIFO_PTR 3'h1
`define UAFS_OFF_FIFO_WIN 3'h2
`define UAFS_OFF_IRQ_STATUS 3'h3
`define UAFS_OFF_TOKEN 3'h4
`define UAFS_OFF_CTRL 3'h5
`define UAFS_BIT_STALL 0
`define UAFS_BIT_BUSY 1
`define UAFS_BIT_IDLE 2
`define UAFS_BIT_WAKE 3
`define UAFS_BIT_EP1_TX 5
`define UAFS_BIT_EP0_TX 6
`define UAFS_BIT_EP0_RX 7
`define UAFS_BIT_TOKEN 6
`define UAFS_RST_BYTE 8'h00
`define UAFS_IDLE_US 3000
`define UAFS_CLK_MHZ 100
`define UAFS_IDLE_CYC (`UAFS_IDLE_US * `UAFS_CLK_MHZ)
`endif

// ### rtl/uafs_pkg.sv
// Purpose: shared types for the application status interface
// Assumes: nothing
// Notes: constants live in uafs_regs.svh
package uafs_pkg;
	typedef logic [7:0] uafs_byte_t;
	typedef logic [4:0] uafs_ptr_t;
	typedef enum logic [1:0] {UAFS_FIFO_IDLE, UAFS_FIFO_WR, UAFS_FIFO_RD} uafs_fifo_op_t;
endpackage : uafs_pkg

// ### rtl/uafs_link_if.sv
// Purpose: link between firmware-side register block and USB device core
// Assumes: one clock, both ends synchronous to it
// Notes: device end owns flags; core end pulses events
`timescale 1ns/10ps
`default_nettype none
interface uafs_link_if (input wire logic sys_clk);
	import uafs_pkg::*;
	// flags toward core
	logic stallReq;
	logic wakeReq;
	logic ep0TxReq;
	logic ep1TxReq;
	logic ep0RxFull;
	// core events
	logic setupOk;
	logic ep0TxDone;
	logic ep1TxDone;
	logic ep0RxDone;
	logic busActive;
	logic suspendSig;
	logic busReset;
	logic vendorCmd;
	logic tokenSeen;
	// core FIFO access
	uafs_fifo_op_t coreOp;
	uafs_ptr_t coreAddr;
	uafs_byte_t coreWrData;
	uafs_byte_t coreRdData;
	modport device (
		input setupOk, ep0TxDone, ep1TxDone, ep0RxDone, busActive, suspendSig,
		input busReset, vendorCmd, tokenSeen, coreOp, coreAddr, coreWrData,
		output stallReq, wakeReq, ep0TxReq, ep1TxReq, ep0RxFull, coreRdData
	);
	modport core (
		output setupOk, ep0TxDone, ep1TxDone, ep0RxDone, busActive, suspendSig,
		output busReset, vendorCmd, tokenSeen, coreOp, coreAddr, coreWrData,
		input stallReq, wakeReq, ep0TxReq, ep1TxReq, ep0RxFull, coreRdData
	);
endinterface : uafs_link_if
`default_nettype wire

// ### rtl/uafs_sync2.sv
// Purpose: two-flop synchroniser for a vector of pins
// Assumes: inputs asynchronous to sys_clk
// Notes: first stage read only by second
`timescale 1ns/10ps
`default_nettype none
module uafs_sync2 #(parameter int W = 4) (
	// clock
	input wire logic sys_clk,
	input wire logic reset,
	// data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule : uafs_sync2
`default_nettype wire

// ### rtl/uafs_device.sv
// Purpose: firmware register block over Avalon-MM, flags, FIFO, irq status
// Assumes: core end on same clock; pins async
// Notes: 32-entry byte FIFO in flops, shared with the core
//
// Implementation choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
`include "uafs_regs.svh"
module uafs_device
	import uafs_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// avalon slave
	input wire logic [2:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsWriteData,
	output logic [31:0] avsReadData,
	output logic avsWaitRequest,
	// asynchronous event inputs
	input wire logic timerOverflow,
	input wire logic [1:0] port5Lines,
	input wire logic highPatternEvt,
	input wire logic lowPatternEvt,
	// link to core
	uafs_link_if.device link
);
	typedef struct packed {
		uafs_byte_t [31:0] fifo;
		uafs_ptr_t ptr;
		logic stall, idle, wake, ep1Tx, ep0Tx, ep0Rx;
		uafs_byte_t irq;
		logic token;
		logic dualClk;
		logic suspPrev;
		logic [1:0] p5Prev;
		logic [3:0] evtPrev;
		logic [$clog2(`UAFS_IDLE_CYC+1)-1:0] idleCnt;
		logic ack;
		logic [31:0] rdata;
		uafs_byte_t coreRd;
	} uafs_dev_state_t;

	uafs_dev_state_t st_r, st_nxt;
	logic [1:0] p5Sync;
	logic [2:0] evtSync;
	logic busy;
	uafs_byte_t statusByte;
	uafs_byte_t w8;
	logic wr, rd;
	// edge and interrupt helpers
	logic suspFall;
	wire logic [2:0] evtRise;
	wire uafs_byte_t irqSet;

	uafs_sync2 #(.W(5)) pinSync (
		.sys_clk(sys_clk),
		.reset(reset),
		.d({timerOverflow, highPatternEvt, lowPatternEvt, port5Lines}),
		.q({evtSync, p5Sync})
	);

	assign busy = (link.coreOp != UAFS_FIFO_IDLE);
	assign w8 = avsWriteData[7:0];
	// write lands at the edge that samples waitrequest low
	assign wr = avsWrite && st_r.ack;
	assign rd = avsRead && !st_r.ack;
	assign statusByte = {st_r.ep0Rx, st_r.ep0Tx, st_r.ep1Tx, 1'b0, st_r.wake,
		st_r.idle, busy, st_r.stall};
	assign suspFall = st_r.suspPrev && !link.suspendSig;

	// rising edges of the synchronised event pins
	for (genvar gi = 0; gi < 3; gi++) begin : g_evtRise
		assign evtRise[gi] = evtSync[gi] && !st_r.evtPrev[gi];
	end

	// hardware set condition of each interrupt flag
	assign irqSet[0] = evtRise[2];
	assign irqSet[1] = link.vendorCmd;
	assign irqSet[2] = link.suspendSig && !st_r.suspPrev;
	assign irqSet[3] = link.busReset;
	assign irqSet[4] = st_r.dualClk && suspFall;
	assign irqSet[5] = (p5Sync != st_r.p5Prev);
	assign irqSet[6] = evtRise[0];
	assign irqSet[7] = evtRise[1];

	always_comb begin
		st_nxt = st_r;
		st_nxt.ack = (avsRead || avsWrite) && !st_r.ack;
		st_nxt.suspPrev = link.suspendSig;
		st_nxt.p5Prev = p5Sync;
		st_nxt.evtPrev = {1'b0, evtSync};
		// firmware writes
		if (wr) begin
			case (avsAddress)
				`UAFS_OFF_APP_STATUS: begin
					st_nxt.stall = w8[`UAFS_BIT_STALL];
					st_nxt.ep0Rx = w8[`UAFS_BIT_EP0_RX];
					// wake and tx requests set-only, busy and idle read-only
					if (w8[`UAFS_BIT_WAKE]) st_nxt.wake = 1'b1;
					if (w8[`UAFS_BIT_EP0_TX]) st_nxt.ep0Tx = 1'b1;
					if (w8[`UAFS_BIT_EP1_TX]) st_nxt.ep1Tx = 1'b1;
				end
				`UAFS_OFF_FIFO_PTR: begin
					st_nxt.ptr = w8[4:0];
				end
				`UAFS_OFF_FIFO_WIN: begin
					st_nxt.fifo[st_r.ptr] = w8;
				end
				`UAFS_OFF_IRQ_STATUS: begin
					st_nxt.irq = st_r.irq & w8;
				end
				`UAFS_OFF_TOKEN: begin
					if (!w8[`UAFS_BIT_TOKEN]) st_nxt.token = 1'b0;
				end
				`UAFS_OFF_CTRL: begin
					st_nxt.dualClk = w8[0];
				end
				default: begin
				end
			endcase
		end

		// core FIFO port; a core write beats a window write
		if (link.coreOp == UAFS_FIFO_WR) begin
			st_nxt.fifo[link.coreAddr] = link.coreWrData;
		end
		st_nxt.coreRd = st_r.fifo[link.coreAddr];
		// hardware set/clear wins over firmware
		if (link.setupOk) begin
			st_nxt.stall = 1'b0;
		end
		if (suspFall) begin
			st_nxt.wake = 1'b0;
		end
		if (link.ep0TxDone) begin
			st_nxt.ep0Tx = 1'b0;
		end
		if (link.ep1TxDone) begin
			st_nxt.ep1Tx = 1'b0;
		end
		if (link.ep0RxDone) begin
			st_nxt.ep0Rx = 1'b1;
		end
		if (link.tokenSeen) begin
			st_nxt.token = 1'b1;
		end
		// idle timer
		if (link.busActive) begin
			st_nxt.idleCnt = '0;
			st_nxt.idle = 1'b0;
		end else if (st_r.idleCnt == ($bits(st_r.idleCnt))'(`UAFS_IDLE_CYC - 1)) begin
			st_nxt.idle = 1'b1;
		end else begin
			st_nxt.idleCnt = st_r.idleCnt + 1'b1;
		end
		// interrupt flags: a hardware set beats a clear in the same cycle
		st_nxt.irq = st_nxt.irq | irqSet;

		// read data, snapshot taken when the request is first seen
		st_nxt.rdata = 32'h0000_0000;
		if (rd) begin
			case (avsAddress)
				`UAFS_OFF_APP_STATUS: begin
					st_nxt.rdata = {24'h00_0000, statusByte};
				end
				`UAFS_OFF_FIFO_PTR: begin
					st_nxt.rdata = {27'h000_0000, st_r.ptr};
				end
				`UAFS_OFF_FIFO_WIN: begin
					st_nxt.rdata = {24'h00_0000, st_r.fifo[st_r.ptr]};
				end
				`UAFS_OFF_IRQ_STATUS: begin
					st_nxt.rdata = {24'h00_0000, st_r.irq};
				end
				`UAFS_OFF_TOKEN: begin
					st_nxt.rdata = {25'h000_0000, st_r.token, 6'h00};
				end
				`UAFS_OFF_CTRL: begin
					st_nxt.rdata = {31'h0000_0000, st_r.dualClk};
				end
				default: begin
					st_nxt.rdata = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign avsReadData = st_r.rdata;
	assign avsWaitRequest = !st_r.ack;
	assign link.stallReq = st_r.stall;
	assign link.wakeReq = st_r.wake;
	assign link.ep0TxReq = st_r.ep0Tx;
	assign link.ep1TxReq = st_r.ep1Tx;
	assign link.ep0RxFull = st_r.ep0Rx;
	assign link.coreRdData = st_r.coreRd;
endmodule : uafs_device
`default_nettype wire

// ### rtl/uafs_core.sv
// Purpose: USB device core end: FIFO transfers gated by flags
// Assumes: user side gives protocol events as one-cycle pulses
// Notes: one FIFO op at a time, 32-byte read burst, writes up to 32 bytes
`timescale 1ns/10ps
`default_nettype none
`include "uafs_regs.svh"
module uafs_core
	import uafs_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// protocol events from user side
	input wire logic rxPkt,
	input wire logic [7:0] rxByte,
	input wire logic rxLast,
	input wire logic setupOk,
	input wire logic busActive,
	input wire logic suspendSig,
	input wire logic busReset,
	input wire logic vendorCmd,
	input wire logic tokenSeen,
	// user-side results
	output logic stallOut,
	output logic wakeOut,
	output logic txValid,
	output logic [7:0] txByte,
	output logic rxRefused,
	// link
	uafs_link_if.core link
);
	typedef struct packed {
		uafs_fifo_op_t op;
		uafs_ptr_t addr;
		uafs_byte_t wdata;
		logic ep;
		logic txDone0, txDone1, rxDone;
		logic stall, wake, txV, refused;
		uafs_byte_t txB;
		logic lastSeen;
		logic tail;
	} uafs_core_state_t;

	uafs_core_state_t st_r, st_nxt;
	logic txDoneWait;

	// tx request flag drops only one cycle after the done pulse
	assign txDoneWait = st_r.txDone0 || st_r.txDone1;

	always_comb begin
		st_nxt = st_r;
		st_nxt.txDone0 = 1'b0;
		st_nxt.txDone1 = 1'b0;
		st_nxt.rxDone = 1'b0;
		st_nxt.txV = 1'b0;
		st_nxt.refused = 1'b0;
		st_nxt.stall = link.stallReq;
		st_nxt.wake = link.wakeReq;
		case (st_r.op)
			UAFS_FIFO_IDLE: begin
				st_nxt.addr = '0;
				// a pending done pulse means the rx flag is about to rise
				if (rxPkt && !link.ep0RxFull && !st_r.rxDone) begin
					st_nxt.op = UAFS_FIFO_WR;
					st_nxt.wdata = rxByte;
					st_nxt.lastSeen = rxLast;
				end else if (rxPkt) begin
					st_nxt.refused = 1'b1;
				end else if ((link.ep0TxReq || link.ep1TxReq) && !txDoneWait) begin
					st_nxt.op = UAFS_FIFO_RD;
					st_nxt.ep = !link.ep0TxReq;
				end
			end
			UAFS_FIFO_WR: begin
				if (st_r.lastSeen) begin
					st_nxt.op = UAFS_FIFO_IDLE;
					st_nxt.rxDone = 1'b1;
				end else if (rxPkt) begin
					st_nxt.addr = st_r.addr + 1'b1;
					st_nxt.wdata = rxByte;
					st_nxt.lastSeen = rxLast || (st_r.addr == 5'h1e);
				end
			end
			UAFS_FIFO_RD: begin
				// read data trails the address by one cycle: one tail cycle
				st_nxt.txV = (st_r.addr != 5'h00) || st_r.tail;
				st_nxt.txB = link.coreRdData;
				if (st_r.tail) begin
					st_nxt.tail = 1'b0;
					st_nxt.op = UAFS_FIFO_IDLE;
					if (st_r.ep) st_nxt.txDone1 = 1'b1;
					else st_nxt.txDone0 = 1'b1;
				end else begin
					st_nxt.addr = st_r.addr + 1'b1;
					st_nxt.tail = (st_r.addr == 5'h1f);
				end
			end
			default: st_nxt.op = UAFS_FIFO_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign link.coreOp = st_r.op;
	assign link.coreAddr = st_r.addr;
	assign link.coreWrData = st_r.wdata;
	assign link.ep0TxDone = st_r.txDone0;
	assign link.ep1TxDone = st_r.txDone1;
	assign link.ep0RxDone = st_r.rxDone;
	assign link.setupOk = setupOk;
	assign link.busActive = busActive;
	assign link.suspendSig = suspendSig;
	assign link.busReset = busReset;
	assign link.vendorCmd = vendorCmd;
	assign link.tokenSeen = tokenSeen;
	assign stallOut = st_r.stall;
	assign wakeOut = st_r.wake;
	assign txValid = st_r.txV;
	assign txByte = st_r.txB;
	assign rxRefused = st_r.refused;
endmodule : uafs_core
`default_nettype wire

// ### sim/uafs_properties.sv
// Purpose: link checks between the device and core ends
// Assumes: one clock, sync reset
// Notes: sees interface signals only
`timescale 1ns/10ps
`default_nettype none
module uafs_properties
	import uafs_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// link signals
	input wire logic stallReq,
	input wire logic wakeReq,
	input wire logic ep0TxReq,
	input wire logic ep1TxReq,
	input wire logic ep0RxFull,
	input wire logic setupOk,
	input wire logic ep0TxDone,
	input wire logic ep1TxDone,
	input wire logic ep0RxDone,
	input wire logic suspendSig,
	input wire uafs_fifo_op_t coreOp
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	property p_stall_clr; setupOk |=> !stallReq; endproperty
	a_stall_clr: assert property (p_stall_clr) else $error("stall kept after setup");
	property p_stall_rise; $rose(stallReq) |-> !$past(setupOk); endproperty
	a_stall_rise: assert property (p_stall_rise) else $error("stall set against setup");
	property p_wake_clr; $fell(suspendSig) |=> !wakeReq; endproperty
	a_wake_clr: assert property (p_wake_clr) else $error("wake kept after suspend");
	property p_tx0_clr; ep0TxDone |=> !ep0TxReq; endproperty
	a_tx0_clr: assert property (p_tx0_clr) else $error("ep0 request kept");
	property p_tx1_clr; ep1TxDone |=> !ep1TxReq; endproperty
	a_tx1_clr: assert property (p_tx1_clr) else $error("ep1 request kept");
	property p_tx1_go; $rose(ep1TxReq) |-> ##[1:80] coreOp == UAFS_FIFO_RD; endproperty
	a_tx1_go: assert property (p_tx1_go) else $error("ep1 read not started");
	property p_rx_set; ep0RxDone |=> ep0RxFull; endproperty
	a_rx_set: assert property (p_rx_set) else $error("rx flag not set");
	property p_rx_lock; ep0RxFull && coreOp == UAFS_FIFO_IDLE |=> coreOp != UAFS_FIFO_WR; endproperty
	a_rx_lock: assert property (p_rx_lock) else $error("write while rx flag set");
endmodule : uafs_properties
`default_nettype wire

// ### sim/tb_top.sv
// Purpose: drives firmware bus and protocol side of both ends
// Assumes: 100 MHz clock, sync reset
// Notes: random data from a fixed seed
`timescale 1ns/10ps
`default_nettype none
`include "uafs_regs.svh"
module tb_top;
	localparam logic [2:0] oApp = `UAFS_OFF_APP_STATUS;
	localparam logic [2:0] oPtr = `UAFS_OFF_FIFO_PTR;
	localparam logic [2:0] oWin = `UAFS_OFF_FIFO_WIN;
	localparam logic [2:0] oIrq = `UAFS_OFF_IRQ_STATUS;
	localparam logic [2:0] oTok = `UAFS_OFF_TOKEN;
	logic sys_clk, reset, avsRead, avsWrite, avsWaitRequest, rxPkt, rxLast, setupOk, busActive;
	logic suspendSig, busReset, vendorCmd, tokenSeen, timerOverflow, highPatternEvt;
	logic lowPatternEvt, stallOut, wakeOut, txValid, rxRefused;
	logic [2:0] avsAddress;
	logic [31:0] avsWriteData, avsReadData;
	logic [1:0] port5Lines;
	logic [7:0] rxByte, txByte, q, mem [32], txq [$];
	int fails, cmpCount, cyc, refusals, seed, len, n;
	int ks [6] = '{0, 1, 3, 5, 6, 7};
	uafs_link_if lnk (.sys_clk(sys_clk));
	uafs_device u_uafs_device (.sys_clk(sys_clk), .reset(reset), .avsAddress(avsAddress),
		.avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
		.avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .timerOverflow(timerOverflow),
		.port5Lines(port5Lines), .highPatternEvt(highPatternEvt), .lowPatternEvt(lowPatternEvt),
		.link(lnk));
	uafs_core u_uafs_core (.sys_clk(sys_clk), .reset(reset), .rxPkt(rxPkt), .rxByte(rxByte),
		.rxLast(rxLast), .setupOk(setupOk), .busActive(busActive), .suspendSig(suspendSig),
		.busReset(busReset), .vendorCmd(vendorCmd), .tokenSeen(tokenSeen), .stallOut(stallOut),
		.wakeOut(wakeOut), .txValid(txValid), .txByte(txByte), .rxRefused(rxRefused), .link(lnk));
	uafs_properties u_uafs_properties (.sys_clk(sys_clk), .reset(reset),
		.stallReq(lnk.stallReq), .wakeReq(lnk.wakeReq), .ep0TxReq(lnk.ep0TxReq),
		.ep1TxReq(lnk.ep1TxReq), .ep0RxFull(lnk.ep0RxFull), .setupOk(lnk.setupOk),
		.ep0TxDone(lnk.ep0TxDone), .ep1TxDone(lnk.ep1TxDone), .ep0RxDone(lnk.ep0RxDone),
		.suspendSig(lnk.suspendSig), .coreOp(lnk.coreOp));
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	function automatic logic [7:0] irqBit(input int k);
		return 8'h01 << k;
	endfunction : irqBit
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmpCount, fails);
		if (fails == 0 && cmpCount > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		cmpCount++;
		if (g !== e) begin
			$display("[FAIL] %s exp %h got %h", nm, e, g);
			fails++;
		end
	endtask : chk
	// one bus access, held until the edge that samples waitrequest low
	task automatic av(input logic w, input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		avsAddress <= a;
		avsWrite <= w;
		avsRead <= !w;
		avsWriteData <= {24'h00_0000, d};
		do begin
			@(posedge sys_clk);
		end while (avsWaitRequest !== 1'b0);
		q = avsReadData[7:0];
		avsRead <= 1'b0;
		avsWrite <= 1'b0;
	endtask : av
	task automatic rd(input logic [2:0] a, input logic [7:0] e, input string nm);
		av(1'b0, a, 8'h00);
		chk(nm, e, q);
	endtask : rd
	task automatic ev(input int k);
		@(posedge sys_clk);
		case (k)
			0: timerOverflow <= 1'b1;
			1: vendorCmd <= 1'b1;
			2: suspendSig <= 1'b1;
			3: busReset <= 1'b1;
			5: port5Lines <= port5Lines ^ 2'h1;
			6: lowPatternEvt <= 1'b1;
			7: highPatternEvt <= 1'b1;
			8: setupOk <= 1'b1;
			9: tokenSeen <= 1'b1;
			default: suspendSig <= 1'b0;
		endcase
		@(posedge sys_clk);
		{timerOverflow, vendorCmd, busReset, lowPatternEvt, highPatternEvt, setupOk} <= 6'h00;
		tokenSeen <= 1'b0;
		repeat (4) @(posedge sys_clk);
	endtask : ev
	always @(negedge sys_clk) begin
		cyc++;
		if (txValid === 1'b1) txq.push_back(txByte);
		if (rxRefused === 1'b1) refusals++;
		if (cyc == 20000) begin
			fails++;
			end_sim();
		end
	end
	initial begin
		{avsRead, avsWrite, rxPkt, rxLast, setupOk, suspendSig, busReset, vendorCmd} = 8'h00;
		{tokenSeen, timerOverflow, highPatternEvt, lowPatternEvt, port5Lines} = 6'h00;
		{avsAddress, avsWriteData, rxByte} = 43'h000_0000_0000;
		busActive = 1'b1;
		reset = 1'b1;
		seed = 32'hb639_cbf4;
		repeat (20) @(posedge sys_clk);
		reset <= 1'b0;
		for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00, "reset value");
		av(1'b1, 3'h6, 8'hff);
		rd(3'h6, 8'h00, "unmapped");
		rd(oApp, 8'h00, "tx idle before fill");
		av(1'b1, oApp, 8'h80);
		for (int i = 0; i < 32; i++) begin
			mem[i] = 8'($random(seed));
			av(1'b1, oPtr, {mem[i][7:5], i[4:0]});
			rd(oPtr, {3'h0, i[4:0]}, "pointer");
			av(1'b1, oWin, mem[i]);
		end
		for (int b = 6; b > 4; b--) begin
			txq.delete();
			av(1'b1, oApp, irqBit(b));
			rd(oApp, irqBit(b) | 8'h02, "busy with request");
			n = 0;
			do begin
				av(1'b0, oApp, 8'h00);
				n++;
			end while (q !== 8'h00 && n < 60);
			chk("request cleared", 8'h00, q);
			chk("tx count", 8'd32, 8'(txq.size()));
			for (int i = 0; i < 32; i++) chk("tx byte", mem[i], txq[i]);
		end
		len = 1 + int'($unsigned($random(seed)) % 5);
		for (int i = 0; i < len + 1; i++) begin
			@(posedge sys_clk);
			mem[i] = 8'($random(seed));
			rxPkt <= 1'b1;
			rxByte <= mem[i];
			rxLast <= (i >= len - 1);
			@(posedge sys_clk);
			rxPkt <= 1'b0;
			if (i == len - 1) repeat (8) @(posedge sys_clk);
		end
		rd(oApp, 8'h80, "rx flag");
		chk("refused", 8'h01, 8'(refusals));
		for (int i = 0; i < len; i++) begin
			av(1'b1, oPtr, 8'(i));
			rd(oWin, mem[i], "rx byte");
		end
		av(1'b1, oApp, 8'h01);
		rd(oApp, 8'h01, "stall and rx clear");
		chk("stall out", 8'h01, {7'h00, stallOut});
		ev(8);
		rd(oApp, 8'h00, "stall after setup");
		foreach (ks[i]) begin
			ev(ks[i]);
			rd(oIrq, irqBit(ks[i]), "irq set");
			av(1'b1, oIrq, ~irqBit(ks[i]));
			rd(oIrq, 8'h00, "irq clear");
		end
		av(1'b1, `UAFS_OFF_CTRL, 8'h01);
		ev(2);
		rd(oIrq, 8'h04, "suspend irq");
		av(1'b1, oApp, 8'h08);
		rd(oApp, 8'h08, "wake set");
		chk("wake out", 8'h01, {7'h00, wakeOut});
		ev(10);
		rd(oApp, 8'h00, "wake cleared");
		rd(oIrq, 8'h14, "resume irq");
		ev(9);
		rd(oTok, 8'h40, "token");
		av(1'b1, oTok, 8'h00);
		rd(oTok, 8'h00, "token clear");
		end_sim();
	end
endmodule : tb_top
`default_nettype wire
